// ===== hw/fhr_pkg.sv
package fhr_pkg;

  // Register indexes; byte address is four times the index
  localparam logic [13:0] FHR_IDX_SETUP    = 14'h03f0;
  localparam logic [13:0] FHR_IDX_DRVCTL   = 14'h03f2;
  localparam logic [13:0] FHR_IDX_STATUS   = 14'h03f4;
  localparam logic [13:0] FHR_IDX_DATA     = 14'h03f5;
  localparam logic [13:0] FHR_IDX_INPUT    = 14'h03f7;

  // Buffer geometry
  localparam logic [4:0]  FHR_DEPTH        = 5'h10;
  localparam logic [4:0]  FHR_SINGLE       = 5'h01;
  localparam logic [7:0]  FHR_FILL_BYTE    = 8'h00;

  // Setup register fields
  localparam int          FHR_SET_FIFO_EN  = 0;
  localparam int          FHR_SET_THR_LO   = 1;
  localparam int          FHR_SET_POLLED   = 5;
  localparam int          FHR_SET_VIEW_LO  = 6;
  localparam int          FHR_SET_FORCE_EN = 8;
  localparam int          FHR_SET_FORCE_V  = 9;

  // Drive control fields
  localparam int          FHR_DRV_RUN      = 2;
  localparam int          FHR_DRV_DMA      = 3;

  // Rate select / rate config fields
  localparam int          FHR_RATE_SWRST   = 7;
  localparam int          FHR_CFG_NO_PRECOMP_FLAG   = 2;

  // Reset values
  localparam logic [1:0]  FHR_RATE_RST     = 2'b10;
  localparam logic [9:0]  FHR_SETUP_RST    = 10'h000;
  localparam logic [7:0]  FHR_DRVCTL_RST   = 8'h00;
  localparam logic        FHR_DENS_RST     = 1'b1;

  typedef enum logic [1:0] {
    FHR_PH_IDLE   = 2'b00,
    FHR_PH_CMD    = 2'b01,
    FHR_PH_EXEC   = 2'b10,
    FHR_PH_RESULT = 2'b11
  } fhr_phase_type;

  typedef enum logic [1:0] {
    FHR_VIEW_BASIC = 2'b00,
    FHR_VIEW_RATE  = 2'b01,
    FHR_VIEW_FULL  = 2'b10,
    FHR_VIEW_SPARE = 2'b11
  } fhr_view_type;

endpackage

// ===== hw/fhr_regs.sv
`timescale 1ns/1ps

module fhr_regs
  import fhr_pkg::*;
(
  input  wire logic        sys_clk_i,
  input  wire logic        rst_b_i,
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [15:0] paddr_i,
  input  wire logic [31:0] pwdata_i,
  output logic      [31:0] prdata_o,
  output logic             pready_o,
  output logic             pslverr_o,
  input  wire logic [1:0]  core_phase_i,
  input  wire logic        core_read_dir_i,
  input  wire logic        core_put_i,
  input  wire logic [7:0]  core_put_data_i,
  input  wire logic        core_take_i,
  input  wire logic [3:0]  drive_busy_i,
  input  wire logic        media_change_b_i,
  output logic             core_take_valid_o,
  output logic      [7:0]  core_take_data_o,
  output logic             core_put_ready_o,
  output logic             core_abort_o,
  output logic             core_fill_zero_o,
  output logic             core_reset_o,
  output logic             service_req_o,
  output logic      [1:0]  rate_code_o,
  output logic             density_select_pin_o,
  output logic             dma_gate_flag_o
);

  function automatic logic addr_hit(input logic [15:0] addr, input logic [13:0] idx);
    addr_hit = (addr[15:2] == idx) && (addr[1:0] == 2'b00);
  endfunction

  // Standard drive type: high density for 500K and 1M
  function automatic logic dens_of(input logic [1:0] code);
    dens_of = (code == 2'b00) || (code == 2'b11);
  endfunction

  logic        pready_q;
  logic [31:0] prdata_q;
  logic        pslverr_q;
  logic [9:0]  setup_q;
  logic [7:0]  drvctl_q;
  logic [1:0]  rate_q;
  logic [1:0]  rate_d;
  logic        no_precomp_flag_q;
  logic        swrst_q;
  logic        dens_q;
  logic [1:0]  prev_phase_q;
  logic [7:0]  mem_q [16];
  logic [3:0]  wr_ptr_q;
  logic [3:0]  rd_ptr_q;
  logic [4:0]  count_q;
  logic [3:0]  wr_ptr_d;
  logic [3:0]  rd_ptr_d;
  logic [4:0]  count_d;
  logic [7:0]  head_q;
  logic [7:0]  head_d;
  logic        abort_q;
  logic        fill_q;
  logic        take_valid_q;
  logic        put_ready_q;
  logic        service_q;
  logic [7:0]  take_data_q;
  logic        core_rst_q;

  // Bus decode
  wire         pready_d   = psel_i & penable_i & ~pready_q;
  wire         acc        = psel_i & penable_i & pready_q;
  wire         wr_acc     = acc & pwrite_i;
  wire         rd_acc     = acc & ~pwrite_i;
  wire         hit_setup  = addr_hit(paddr_i, FHR_IDX_SETUP);
  wire         hit_drvctl = addr_hit(paddr_i, FHR_IDX_DRVCTL);
  wire         hit_status = addr_hit(paddr_i, FHR_IDX_STATUS);
  wire         hit_data   = addr_hit(paddr_i, FHR_IDX_DATA);
  wire         hit_input  = addr_hit(paddr_i, FHR_IDX_INPUT);
  wire         mapped     = hit_setup | hit_drvctl | hit_status | hit_data | hit_input;

  // Setup fields
  wire         fifo_en    = setup_q[FHR_SET_FIFO_EN];
  wire  [4:0]  thr        = {1'b0, setup_q[FHR_SET_THR_LO +: 4]} + 5'h01;
  wire         polled     = setup_q[FHR_SET_POLLED];
  wire  [1:0]  view       = setup_q[FHR_SET_VIEW_LO +: 2];
  wire         force_en   = setup_q[FHR_SET_FORCE_EN];
  wire         force_val  = setup_q[FHR_SET_FORCE_V];
  wire         soft_rst   = ~drvctl_q[FHR_DRV_RUN] | swrst_q;

  // Phase tracking
  wire         in_exec    = core_phase_i == FHR_PH_EXEC;
  wire         enter_exec = in_exec && (prev_phase_q != FHR_PH_EXEC);
  wire         read_dir   = (core_phase_i == FHR_PH_RESULT) | (in_exec & core_read_dir_i);

  // Buffer capacity: single byte unless FIFO enabled in execution
  wire  [4:0]  cap        = (fifo_en & in_exec) ? FHR_DEPTH : FHR_SINGLE;
  wire         empty      = count_q == 5'h00;
  wire         full       = count_q >= cap;
  wire  [4:0]  space      = full ? 5'h00 : cap - count_q;

  // Request and direction flags
  wire         host_request_flag        = ~soft_rst & (read_dir ? ~empty : ~full);
  wire         transfer_direction_flag        = read_dir;
  wire         nondma     = polled & in_exec;
  wire         busy       = core_phase_i != FHR_PH_IDLE;

  // Moves through the shared data port
  wire         host_push  = wr_acc & hit_data & ~read_dir & host_request_flag;
  wire         host_pop   = rd_acc & hit_data & read_dir & host_request_flag;
  wire         core_push  = core_put_i & read_dir & ~full & ~abort_q & ~soft_rst;
  wire         core_pop   = core_take_i & ~read_dir & ~empty & ~abort_q & ~soft_rst;
  wire         push       = host_push | core_push;
  wire         pop        = host_pop | core_pop;
  wire  [7:0]  push_data  = host_push ? pwdata_i[7:0] : core_put_data_i;
  wire         flush      = enter_exec | soft_rst;

  // Service failures
  wire         overrun    = in_exec & read_dir & core_put_i & full & ~abort_q;
  wire         underrun   = in_exec & ~read_dir & core_take_i & empty & ~abort_q;

  // Threshold service request
  wire         thr_met    = read_dir ? (count_q >= thr) : (space >= thr);
  wire         service_d  = ~soft_rst & (fifo_en & in_exec ? thr_met : host_request_flag);

  // Next values for registered outputs
  wire  [7:0]  drvctl_d   = (wr_acc & hit_drvctl) ? pwdata_i[7:0] : drvctl_q;
  wire         fill_d     = underrun | (fill_q & in_exec & ~soft_rst);
  wire  [7:0]  take_byte_d = fill_d ? FHR_FILL_BYTE : head_d;

  // Rate writes from either register
  wire         dsr_wr     = wr_acc & hit_status;
  wire         ccr_wr     = wr_acc & hit_input;
  wire         rate_wr    = dsr_wr | ccr_wr;

  // Read views
  wire         mchg       = force_en ? force_val : ~media_change_b_i;
  wire  [7:0]  status_b   = {host_request_flag, transfer_direction_flag, nondma, busy, drive_busy_i};
  wire  [7:0]  in_basic   = {mchg, 7'h00};
  wire  [7:0]  in_rate    = {mchg, 4'hf, rate_q, ~dens_of(rate_q)};
  wire  [7:0]  in_full    = {mchg, 3'h0, drvctl_q[FHR_DRV_DMA], no_precomp_flag_q, rate_q};
  wire  [7:0]  in_byte    = (view == FHR_VIEW_RATE) ? in_rate :
                            (view == FHR_VIEW_FULL) ? in_full : in_basic;
  wire  [7:0]  data_byte  = (read_dir & host_request_flag) ? head_q : 8'h00;
  wire  [7:0]  rd_byte    = hit_status ? status_b :
                            hit_data   ? data_byte :
                            hit_input  ? in_byte :
                            hit_drvctl ? drvctl_q : 8'h00;
  wire  [31:0] rd_word    = hit_setup ? {22'h0, setup_q} : {24'h000000, rd_byte};

  always_comb begin
    rate_d = rate_q;
    if (dsr_wr) begin
      rate_d = pwdata_i[1:0];
    end else if (ccr_wr) begin
      rate_d = pwdata_i[1:0];
    end
  end

  always_comb begin
    wr_ptr_d = wr_ptr_q;
    rd_ptr_d = rd_ptr_q;
    count_d  = count_q;
    if (flush) begin
      wr_ptr_d = 4'h0;
      rd_ptr_d = 4'h0;
      count_d  = 5'h00;
    end else begin
      if (push) begin
        wr_ptr_d = wr_ptr_q + 4'h1;
      end
      if (pop) begin
        rd_ptr_d = rd_ptr_q + 4'h1;
      end
      count_d = count_q + {4'h0, push} - {4'h0, pop};
    end
  end

  always_comb begin
    head_d = FHR_FILL_BYTE;
    if (count_d != 5'h00) begin
      if (push && (rd_ptr_d == wr_ptr_q)) begin
        head_d = push_data;
      end else begin
        head_d = mem_q[rd_ptr_d];
      end
    end
  end

  // Bus slave
  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      pready_q  <= 1'b0;
      prdata_q  <= 32'h00000000;
      pslverr_q <= 1'b0;
    end else begin
      pready_q  <= pready_d;
      pslverr_q <= pready_d & ~mapped;
      prdata_q  <= (pready_d & ~pwrite_i) ? rd_word : 32'h00000000;
    end
  end

  // Control registers
  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      setup_q  <= FHR_SETUP_RST;
      drvctl_q <= FHR_DRVCTL_RST;
      swrst_q  <= 1'b0;
    end else begin
      swrst_q <= dsr_wr & pwdata_i[FHR_RATE_SWRST];
      if (wr_acc && hit_drvctl) begin
        drvctl_q <= pwdata_i[7:0];
      end
      if (wr_acc && hit_setup) begin
        setup_q <= pwdata_i[9:0];
      end else if (soft_rst) begin
        setup_q[FHR_SET_FIFO_EN] <= 1'b0;
        setup_q[FHR_SET_THR_LO +: 4] <= 4'h0;
      end
    end
  end

  // Rate, no-precomp and density; hard reset only
  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rate_q   <= FHR_RATE_RST;
      no_precomp_flag_q <= 1'b0;
      dens_q   <= FHR_DENS_RST;
    end else begin
      rate_q <= rate_d;
      // Density moves only with a rate write
      if (rate_wr) begin
        dens_q <= dens_of(rate_d);
      end
      if (ccr_wr && (view == FHR_VIEW_FULL)) begin
        no_precomp_flag_q <= pwdata_i[FHR_CFG_NO_PRECOMP_FLAG];
      end
    end
  end

  // Buffer storage
  always_ff @(posedge sys_clk_i) begin
    if (push && !flush) begin
      mem_q[wr_ptr_q] <= push_data;
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      wr_ptr_q     <= 4'h0;
      rd_ptr_q     <= 4'h0;
      count_q      <= 5'h00;
      head_q       <= FHR_FILL_BYTE;
      prev_phase_q <= FHR_PH_IDLE;
    end else begin
      wr_ptr_q     <= wr_ptr_d;
      rd_ptr_q     <= rd_ptr_d;
      count_q      <= count_d;
      head_q       <= head_d;
      prev_phase_q <= core_phase_i;
    end
  end

  // Termination state; a new failure wins over the clear
  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      abort_q <= 1'b0;
      fill_q  <= 1'b0;
    end else begin
      if (overrun || underrun) begin
        abort_q <= 1'b1;
      end else if (!in_exec || soft_rst) begin
        abort_q <= 1'b0;
      end
      fill_q <= fill_d;
    end
  end

  // Core side flags
  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      take_valid_q <= 1'b0;
      put_ready_q  <= 1'b0;
      service_q    <= 1'b0;
    end else begin
      take_valid_q <= ~flush & ~read_dir & (count_d != 5'h00);
      put_ready_q  <= ~flush & read_dir & (count_d < cap);
      service_q    <= service_d;
    end
  end

  // Output copies of head byte and core reset
  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      take_data_q <= FHR_FILL_BYTE;
      core_rst_q  <= ~FHR_DRVCTL_RST[FHR_DRV_RUN];
    end else begin
      take_data_q <= take_byte_d;
      core_rst_q  <= ~drvctl_d[FHR_DRV_RUN];
    end
  end

  assign prdata_o             = prdata_q;
  assign pready_o             = pready_q;
  assign pslverr_o            = pslverr_q;
  assign core_take_valid_o    = take_valid_q;
  assign core_take_data_o     = take_data_q;
  assign core_put_ready_o     = put_ready_q;
  assign core_abort_o         = abort_q;
  assign core_fill_zero_o     = fill_q;
  assign core_reset_o         = core_rst_q;
  assign service_req_o        = service_q;
  assign rate_code_o          = rate_q;
  assign density_select_pin_o = dens_q;
  assign dma_gate_flag_o      = drvctl_q[FHR_DRV_DMA];

endmodule

// ===== sim/fhr_regs_properties.sv
`timescale 1ns/1ps
module fhr_regs_properties
  import fhr_pkg::*;
(
  input wire logic        sys_clk_i,
  input wire logic        rst_b_i,
  input wire logic        psel_i,
  input wire logic        penable_i,
  input wire logic        pwrite_i,
  input wire logic [15:0] paddr_i,
  input wire logic [31:0] prdata_o,
  input wire logic        pready_o,
  input wire logic [1:0]  core_phase_i,
  input wire logic        core_take_valid_o,
  input wire logic        core_abort_o,
  input wire logic [1:0]  rate_code_o,
  input wire logic        density_select_pin_o
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!rst_b_i);
  sequence setup_s; psel_i && !penable_i; endsequence
  sequence access_s; psel_i && penable_i; endsequence
  sequence exec_entry_s; core_phase_i == 2'b10 && $past(core_phase_i) != 2'b10; endsequence
  chk_one_wait: assert property (
    setup_s ##1 access_s |=> pready_o) else $error("ready not after one wait");
  chk_ready_pulse: assert property (
    pready_o |-> access_s ##1 !pready_o) else $error("ready not a pulse");
  chk_idle_data: assert property (
    !pready_o |-> prdata_o == 32'h0) else $error("read data outside answer");
  chk_byte_lane: assert property (
    pready_o |-> prdata_o[31:8] == 24'h0) else $error("upper read bits set");
  chk_polled_bit: assert property (
    pready_o && !pwrite_i && paddr_i == {FHR_IDX_STATUS, 2'b00}
    && $past(core_phase_i) != 2'b10 |-> !prdata_o[5]) else $error("bit 5 outside execution");
  chk_exec_flush: assert property (
    exec_entry_s |=> !core_take_valid_o) else $error("buffer not flushed");
  chk_abort_exec: assert property (
    core_abort_o |-> $past(core_phase_i) == 2'b10) else $error("abort outside execution");
  chk_dens_map: assert property (
    $changed(rate_code_o) |=> density_select_pin_o == (rate_code_o inside {2'b00, 2'b11}))
    else $error("density mismatch");
  chk_hard_reset: assert property (
    disable iff (1'b0) !rst_b_i ##1 !rst_b_i |-> rate_code_o == 2'b10 && density_select_pin_o)
    else $error("reset values wrong");
endmodule
bind fhr_regs fhr_regs_properties fhr_regs_properties_i (.sys_clk_i, .rst_b_i, .psel_i,
  .penable_i, .pwrite_i, .paddr_i, .prdata_o, .pready_o, .core_phase_i, .core_take_valid_o,
  .core_abort_o, .rate_code_o, .density_select_pin_o);

// ===== sim/fhr_core_model.sv
`timescale 1ns/1ps
module fhr_core_model (
  input  wire logic       clk_i,
  input  wire logic       rst_b_i,
  input  wire logic       put_req_i,
  input  wire logic [7:0] put_byte_i,
  input  wire logic       put_ready_i,
  input  wire logic       take_valid_i,
  input  wire logic [7:0] take_data_i,
  input  wire logic       rude_i,
  output logic            core_put_o,
  output logic      [7:0] core_put_data_o,
  output logic            core_take_o,
  output logic      [7:0] got_o
);
  logic pend_q;
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      pend_q <= 1'b0;
      core_put_o <= 1'b0;
      core_put_data_o <= 8'h00;
      core_take_o <= 1'b0;
      got_o <= 8'h00;
    end else begin
      if (put_req_i) begin
        pend_q <= 1'b1;
        core_put_data_o <= put_byte_i;
      end else if (pend_q && put_ready_i && !core_put_o) begin
        pend_q <= 1'b0;
      end else if (core_put_o) begin
        core_put_data_o <= ~core_put_data_o;
      end
      core_put_o <= pend_q && put_ready_i && !core_put_o;
      // Rude mode takes with nothing ready
      core_take_o <= (take_valid_i || rude_i) && !core_take_o;
      if (core_take_o) begin
        got_o <= take_data_i;
      end
    end
  end
endmodule

// ===== sim/floppy_host_register_interface_test.sv
`timescale 1ns/1ps
`define CHK(a, e) begin tests_run++; if ((a) !== (e)) begin num_errors++; \
  $display("MISMATCH t=%0t got %h exp %h", $time, a, e); end end
module floppy_host_register_interface_test;
  import fhr_pkg::*;
  logic        clk = 0, rst_b = 0, psel = 0, pen = 0, pwr = 0, pready, perr, lerr;
  logic [15:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, rdat;
  logic [1:0]  phase = 0, rate;
  logic        rdir = 0, put, take, tv, pr, abort, fill, creset, sreq, dens, dma;
  logic        chg_b = 1, put_req = 0, rude = 0;
  logic [7:0]  put_d, td, put_b = 0, got;
  int          num_errors = 0, tests_run = 0;
  localparam logic [15:0] A_SET = {FHR_IDX_SETUP, 2'b00}, A_DRV = {FHR_IDX_DRVCTL, 2'b00};
  localparam logic [15:0] A_ST = {FHR_IDX_STATUS, 2'b00}, A_DAT = {FHR_IDX_DATA, 2'b00};
  localparam logic [15:0] A_IN = {FHR_IDX_INPUT, 2'b00};
  always #4 clk = ~clk;
  fhr_regs fhr_regs_i (.sys_clk_i(clk), .rst_b_i(rst_b), .psel_i(psel), .penable_i(pen),
    .pwrite_i(pwr), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
    .pslverr_o(perr), .core_phase_i(phase), .core_read_dir_i(rdir), .core_put_i(put),
    .core_put_data_i(put_d), .core_take_i(take), .drive_busy_i(4'h5),
    .media_change_b_i(chg_b), .core_take_valid_o(tv), .core_take_data_o(td),
    .core_put_ready_o(pr), .core_abort_o(abort), .core_fill_zero_o(fill),
    .core_reset_o(creset), .service_req_o(sreq), .rate_code_o(rate),
    .density_select_pin_o(dens), .dma_gate_flag_o(dma));
  fhr_core_model fhr_core_model_i (.clk_i(clk), .rst_b_i(rst_b), .put_req_i(put_req),
    .put_byte_i(put_b), .put_ready_i(pr), .take_valid_i(tv), .take_data_i(td),
    .rude_i(rude), .core_put_o(put), .core_put_data_o(put_d), .core_take_o(take), .got_o(got));
  task automatic report_and_stop;
    $display("errors %0d checks %0d", num_errors, tests_run);
    if (num_errors == 0 && tests_run > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic apb(input logic w, input logic [15:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    psel <= 1; pwr <= w; paddr <= a; pwdata <= d;
    @(posedge clk) pen <= 1;
    n = 0;
    do begin @(posedge clk); n++; end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin num_errors++; report_and_stop; end
    rdat = prdata; lerr = perr;
    psel <= 0; pen <= 0;
  endtask
  task automatic wr(input logic [15:0] a, input logic [31:0] d);
    apb(1, a, d);
    @(posedge clk);
  endtask
  task automatic rd(input logic [15:0] a, input logic [31:0] e); apb(0, a, 0); `CHK(rdat, e) endtask
  task automatic send(input logic [7:0] b);
    @(posedge clk) begin put_req <= 1; put_b <= b; end
    @(posedge clk) put_req <= 0;
    repeat (4) @(posedge clk);
  endtask
  initial begin
    logic [1:0] c;
    repeat (12) @(posedge clk);
    rst_b <= 1;
    rd(A_ST, 32'h05);
    rd(A_IN, 32'h00);
    chg_b <= 0;
    rd(A_IN, 32'h80);
    rd(16'h0004, 32'h0);
    `CHK(lerr, 1'b1)
    wr(A_SET, 32'h40);
    for (int i = 0; i < 4; i++) begin
      c = i[1:0];
      wr(A_IN, {30'h0, c});
      `CHK(rate, c)
      rd(A_IN, {24'h0, 1'b1, 4'hf, c, !(c == 2'b00 || c == 2'b11)});
    end
    wr(A_ST, 32'h01);
    `CHK(rate, 2'b01)
    wr(A_IN, 32'h02);
    `CHK(rate, 2'b10)
    wr(A_SET, 32'h80);
    wr(A_DRV, 32'h0c);
    `CHK(dma, 1'b1)
    wr(A_IN, 32'h07);
    rd(A_IN, 32'h8f);
    wr(A_ST, 32'h83);
    rd(A_IN, 32'h8f);
    `CHK(dens, 1'b1)
    wr(A_DRV, 32'h08);
    `CHK(creset, 1'b1)
    wr(A_DRV, 32'h0c);
    rd(A_IN, 32'h8f);
    phase <= 2'b01;
    rd(A_ST, 32'h95);
    `CHK(sreq, 1'b1)
    wr(A_DAT, 32'ha5);
    repeat (4) @(posedge clk);
    `CHK(got, 8'ha5)
    phase <= 2'b11;
    send(8'h3c);
    rd(A_ST, 32'hd5);
    rd(A_DAT, 32'h3c);
    wr(A_SET, 32'ha0);
    phase <= 2'b10;
    rdir <= 1;
    send(8'h5a);
    rd(A_ST, 32'hf5);
    rd(A_DAT, 32'h5a);
    rdir <= 0;
    rude <= 1;
    repeat (4) @(posedge clk);
    rude <= 0;
    `CHK(abort, 1'b1)
    `CHK(fill, 1'b1)
    `CHK(td, 8'h00)
    phase <= 2'b00;
    rd(A_ST, 32'h85);
    `CHK(abort, 1'b0)
    wr(A_SET, 32'ha3);
    phase <= 2'b10;
    rdir <= 1;
    send(8'h11);
    `CHK(sreq, 1'b0)
    send(8'h22);
    `CHK(sreq, 1'b1)
    rd(A_DAT, 32'h11);
    rd(A_DAT, 32'h22);
    wr(A_DRV, 32'h08);
    rd(A_SET, 32'ha0);
    wr(A_DRV, 32'h0c);
    rst_b <= 0;
    repeat (2) @(posedge clk);
    `CHK(rate, 2'b10)
    `CHK(creset, 1'b1)
    rst_b <= 1;
    phase <= 2'b00;
    rdir <= 0;
    rd(A_SET, 32'h0);
    `CHK(dens, 1'b1)
    report_and_stop;
  end
endmodule
